// >>> dv/tb.sv
// self-checking bench for the flow-controlled uart fifo block
`timescale 1ns/10ps
module tb import uff_pkg::*;
;
	logic        aclk = 1'h0, aresetn = 1'h0, clear_to_send_in_n = 1'h0, honor_rts = 1'h0;
	logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, err = '0;
	logic [2:0]  s_axi_awprot = '0, s_axi_arprot = '0;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, target = '0, n_tx, d;
	logic [3:0]  s_axi_wstrb = '0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr, br;
	logic        rx_char_valid, tx_char_valid, tx_char_ready, request_to_send_out_n, irq_out;
	logic [7:0]  rx_char_data, rx_char_status, tx_char_data, last_tx;
	int          cyc = 0, err_total = 0, n_checks = 0;

	uff_flow_ctrl #(.DEPTH(UFF_DEPTH)) uut (.*);
	uff_far_uart far (.*);

	always #20 aclk = ~aclk;

	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			final_report;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic w(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= s;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end
		while (!s_axi_bvalid);
		// ready stays up; lowering it here would collide with the next call
		br = s_axi_bresp;
	endtask

	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end
		while (!s_axi_rvalid);
		d = s_axi_rdata;
		rr = s_axi_rresp;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(d, exp);
	endtask

	// 65th word must vanish: 256 bytes held by the gate, then released
	task automatic t_tx;
		wr(OFS_TX_TRIG, 32'h1, 4'h1);
		wr(OFS_RX_TRIG, 32'h9, 4'h1);
		wr(OFS_FIFO_CTRL, 32'h1, 4'h1);
		wr(OFS_ENH_FEAT, 32'h80, 4'h1);
		for (int i = 0; i < 65; i++)
			wr(OFS_RX_BYTE, 32'h03020100 + i * 32'h04040404, 4'hf);
		rdchk(OFS_TX_FREE, 32'h0);
		rdchk(OFS_INT_STAT, 32'h1);
		chk(n_tx, 32'h0);
		clear_to_send_in_n <= 1'h1;
		w(1500);
		chk(n_tx, 32'h100);
		chk(last_tx, 8'hff);
		rdchk(OFS_TX_FREE, 32'h100);
	endtask

	task automatic t_rts;
		wr(OFS_FIFO_CTRL, 32'h0, 4'h1);
		wr(OFS_INT_EN, 32'h40, 4'h1);
		wr(OFS_ENH_FEAT, 32'h40, 4'h1);
		w(2);
		chk(request_to_send_out_n, 1'h0);
		honor_rts <= 1'h1;
		target <= target + 12;
		w(120);
		chk(request_to_send_out_n, 1'h1);
		chk(irq_out, 1'h1);
		rdchk(OFS_INT_STAT, 32'he0);
		rdchk(OFS_RX_FILL, 32'h9);
		rd(OFS_FLOW_STAT);
		chk(d[FSR_RTS_BIT], 1'h1);
		rd(OFS_MODEM_STAT);
		w(2);
		chk(irq_out, 1'h0);
		rdchk(OFS_RX_WORD, 32'h03020100);
		rdchk(OFS_RX_WORD, 32'h07060504);
		chk(request_to_send_out_n, 1'h1);
		rdchk(OFS_RX_BYTE, 32'h8);
		w(2);
		chk(request_to_send_out_n, 1'h0);
	endtask

	// three held-back clean bytes, then two flagged ones
	task automatic t_err;
		w(20);
		err <= 8'h04;
		target <= target + 2;
		w(20);
		rdchk(OFS_RX_WORD, 32'h00000a09);
		rdchk(OFS_RX_WORD, 32'h04000c0b);
		rdchk(OFS_RX_HALF, 32'h0004000d);
	endtask

	// large mode: thresholds from registers while control bits 7:4 point elsewhere
	task automatic t_big;
		err <= 8'h00;
		wr(OFS_FLOW_UP, 32'h3, 4'h1);
		wr(OFS_FLOW_LO, 32'h1, 4'h1);
		wr(OFS_FIFO_CTRL, 32'hf1, 4'h1);
		chk(br, RESP_OKAY);
		rdchk(OFS_FLOW_UP, 32'h3);
		target <= target + 6;
		w(60);
		rdchk(OFS_RX_FILL, 32'h4);
		chk(irq_out, 1'h1);
		rdchk(OFS_RX_HALF, 32'h00000f0e);
		chk(request_to_send_out_n, 1'h1);
		rdchk(OFS_RX_BYTE, 32'h10);
		w(20);
		chk(request_to_send_out_n, 1'h0);
		rdchk(OFS_RX_WORD, 32'h00131211);
		wr(OFS_FIFO_CTRL, 32'h0, 4'h1);
	endtask

	task automatic t_ovr;
		wr(OFS_ENH_FEAT, 32'h0, 4'h1);
		honor_rts <= 1'h0;
		err <= 8'h00;
		target <= target + 66;
		w(300);
		rdchk(OFS_RX_FILL, 32'h40);
		rd(OFS_LINE_STAT);
		chk(d[LSR_OVR_BIT], 1'h1);
		rdchk(OFS_RX_WORD, 32'h17161514);
		rd(8'h40);
		chk(rr, RESP_SLVERR);
		wr(8'h40, 32'h0, 4'h1);
		chk(br, RESP_SLVERR);
	endtask

	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		w(2);
		chk(request_to_send_out_n, RST_RTS_N);
		t_tx;
		t_rts;
		t_err;
		t_big;
		t_ovr;
		final_report;
	end
endmodule // tb

// >>> dv/uff_far_uart.sv
// far-end uart model: sends received characters, drains transmitted ones
`timescale 1ns/10ps
module uff_far_uart
(
	input  wire logic        aclk,
	input  wire logic        request_to_send_out_n,
	input  wire logic [7:0]  tx_char_data,
	input  wire logic        tx_char_valid,
	output logic             tx_char_ready,
	output logic             rx_char_valid,
	output logic [7:0]       rx_char_data,
	output logic [7:0]       rx_char_status,
	input  wire logic [31:0] target,
	input  wire logic [7:0]  err,
	input  wire logic        honor_rts,
	output logic [31:0]      n_tx,
	output logic [7:0]       last_tx
);
	logic [31:0] ph;
	int          sent;
	initial
	begin
		{tx_char_ready, rx_char_valid, rx_char_data, rx_char_status} = '0;
		{n_tx, last_tx, ph, sent} = '0;
	end
	always @(posedge aclk)
	begin
		ph <= ph + 32'h1;
		rx_char_valid <= 1'h0;
		// idle data toggles so a stale byte is never mistaken for a fresh one
		rx_char_data <= ~rx_char_data;
		// a throttled far end finishes nothing new once rts is seen high
		if (ph[1:0] == 2'h3 && sent < target && !(honor_rts && request_to_send_out_n))
		begin
			rx_char_valid <= 1'h1;
			rx_char_data <= sent[7:0];
			rx_char_status <= err;
			sent <= sent + 1;
		end
		// half-rate shifter so the offer must stand while stalled
		tx_char_ready <= ph[0];
		if (tx_char_valid && tx_char_ready)
		begin
			n_tx <= n_tx + 32'h1;
			last_tx <= tx_char_data;
		end
	end
endmodule // uff_far_uart

// >>> logic/uff_fifo.sv
// multi-byte fifo, rows of LANES entries, up to LANES pushes and pops per cycle
`timescale 1ns/10ps
module uff_fifo import uff_pkg::*;
#(
	parameter int W     = 8,
	parameter int DEPTH = UFF_DEPTH,
	parameter int LANES = UFF_LANES
)
(
	input  wire logic                           aclk,
	input  wire logic                           aresetn,
	input  wire logic [2:0]                     push_cnt,
	input  wire logic [LANES*W-1:0]             push_data,
	input  wire logic [2:0]                     pop_cnt,
	output logic      [LANES*W-1:0]             head_data,
	output logic      [$clog2(DEPTH):0]         fill
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;
	localparam int LW = $clog2(LANES);

	logic [W-1:0]  mem [DEPTH/LANES][LANES];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW-1:0] next_wr_ptr;
	logic [AW-1:0] next_rd_ptr;
	logic [CW-1:0] next_fill;
	logic [AW-1:0] wa [LANES];

	always_comb
	begin
		next_wr_ptr = wr_ptr + AW'(push_cnt);
		next_rd_ptr = rd_ptr + AW'(pop_cnt);
		next_fill   = fill + CW'(push_cnt) - CW'(pop_cnt);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill   <= '0;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			fill   <= next_fill;
		end
	end

	// ****************************************
	// per-lane addressing: row index and lane within row
	// ****************************************
	for (genvar g = 0; g < LANES; g++)
	begin : g_lane
		logic [AW-1:0] ra;
		assign wa[g] = wr_ptr + AW'(g);
		assign ra    = rd_ptr + AW'(g);
		assign head_data[g*W +: W] = mem[ra[AW-1:LW]][ra[LW-1:0]];
	end

	// storage carries no reset; only pointers define contents
	always_ff @(posedge aclk)
	begin
		for (int k = 0; k < LANES; k++)
		begin
			if (k < int'(push_cnt))
				mem[wa[k][AW-1:LW]][wa[k][LW-1:0]] <= push_data[k*W +: W];
		end
	end
endmodule // uff_fifo

// >>> logic/uff_flow_ctrl.sv
// uart fifo block: 256-byte tx/rx/status fifos, axi4-lite registers, rts/cts flow control
`timescale 1ns/10ps
module uff_flow_ctrl import uff_pkg::*;
#(
	parameter int   DEPTH          = UFF_DEPTH,
	parameter logic CTS_STOP_LEVEL = 1'b0
)
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        rx_char_valid,
	input  wire logic [7:0]  rx_char_data,
	input  wire logic [7:0]  rx_char_status,
	output logic [7:0]       tx_char_data,
	output logic             tx_char_valid,
	input  wire logic        tx_char_ready,
	input  wire logic        clear_to_send_in_n,
	output logic             request_to_send_out_n,
	output logic             irq_out
);
	localparam int CW = $clog2(DEPTH) + 1;

	logic [CW-1:0] tx_fill, rx_fill, cap, tx_space, upper, lower;
	logic [31:0]   tx_head;
	logic [63:0]   rx_head;
	logic [2:0]    tx_push, tx_pop, rx_push, rx_pop, strb_cnt, rx_want, rx_take;
	logic          err_pend, cts_sync, wr_fire, rd_fire, rts_rise, cts_rise, cts_hold, rx_drop;
	logic [31:0]   rd_val;
	logic [7:0]    fifo_control_reg, enhanced_feature_reg, interrupt_enable_reg;
	logic [7:0]    tx_trigger_level, rx_trigger_level, flow_upper_threshold, flow_lower_threshold;
	logic [7:0]    next_fcr, next_efr, next_ier, next_ttr, next_rtr, next_fut, next_flt;
	logic          aw_have, w_have, next_aw_have, next_w_have;
	logic [7:0]    aw_addr_q, next_aw_addr;
	logic [31:0]   w_data_q, next_w_data, next_rdata;
	logic [3:0]    w_strb_q, next_w_strb;
	logic          next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0]    next_bresp, next_rresp;
	logic          rts_irq, cts_irq, overrun, next_rts_irq, next_cts_irq, next_overrun;
	logic          next_irq, rts_en_q, next_rts_en, next_rts_n, cts_prev;
	logic [7:0]    next_tx_data;
	logic          next_tx_valid;
	uff_tx_e       tx_state, next_tx_state;

	// ****************************************
	// fifos and pin synchroniser
	// ****************************************
	uff_fifo #(.W(8), .DEPTH(DEPTH), .LANES(UFF_LANES)) u_tx_fifo
	(
		.aclk      (aclk),
		.aresetn   (aresetn),
		.push_cnt  (tx_push),
		.push_data (w_data_q),
		.pop_cnt   (tx_pop),
		.head_data (tx_head),
		.fill      (tx_fill)
	);

	// data and status share one entry so they can never slip apart
	uff_fifo #(.W(16), .DEPTH(DEPTH), .LANES(UFF_LANES)) u_rx_fifo
	(
		.aclk      (aclk),
		.aresetn   (aresetn),
		.push_cnt  (rx_push),
		.push_data ({48'h0, rx_char_status, rx_char_data}),
		.pop_cnt   (rx_pop),
		.head_data (rx_head),
		.fill      (rx_fill)
	);

	uff_sync u_cts_sync
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       (clear_to_send_in_n),
		.q       (cts_sync)
	);

	// ****************************************
	// flow control, receive entry and transmit offer
	// ****************************************
	always_comb
	begin
		cap      = fifo_control_reg[FCR_MODE256_BIT] ? CW'(DEPTH) : CW'(UFF_DEPTH_SMALL);
		tx_space = cap - tx_fill;
		upper    = fifo_control_reg[FCR_MODE256_BIT] ? CW'(flow_upper_threshold)
			: CW'(UPPER_TAB[fifo_control_reg[7:6]]);
		lower    = fifo_control_reg[FCR_MODE256_BIT] ? CW'(flow_lower_threshold)
			: CW'(LOWER_TAB[fifo_control_reg[5:4]]);
		// rx_char_valid arrives once the stop bit is in, so the rise follows it
		rx_push  = (rx_char_valid && rx_fill < cap) ? 3'h1 : 3'h0;
		rx_drop  = rx_char_valid && !(rx_fill < cap);
		next_rts_en = enhanced_feature_reg[EFR_AUTO_RTS];
		next_rts_n  = request_to_send_out_n;
		if (!enhanced_feature_reg[EFR_AUTO_RTS])
			next_rts_n = 1'b1;
		else if (!rts_en_q)
			next_rts_n = 1'b0;
		else if (!request_to_send_out_n && rx_fill > upper)
			next_rts_n = 1'b1;
		else if (request_to_send_out_n && rx_fill <= lower)
			next_rts_n = 1'b0;
		rts_rise = enhanced_feature_reg[EFR_AUTO_RTS] && rts_en_q
			&& !request_to_send_out_n && next_rts_n;
		cts_rise = enhanced_feature_reg[EFR_AUTO_CTS] && !cts_prev && cts_sync;
		cts_hold = enhanced_feature_reg[EFR_AUTO_CTS] && (cts_sync == CTS_STOP_LEVEL);
		next_tx_state = tx_state;
		next_tx_valid = tx_char_valid;
		next_tx_data  = tx_char_data;
		tx_pop        = 3'h0;
		case (tx_state)
			UFF_TX_IDLE:
			begin
				if (tx_fill != '0 && !cts_hold)
				begin
					next_tx_valid = 1'b1;
					next_tx_data  = tx_head[7:0];
					next_tx_state = UFF_TX_OFFER;
				end
			end
			UFF_TX_OFFER:
			begin
				if (tx_char_ready)
				begin
					// once taken the shifter owns it; gating cannot cut it short
					next_tx_valid = 1'b0;
					tx_pop        = 3'h1;
					next_tx_state = UFF_TX_IDLE;
				end
				else if (cts_hold)
				begin
					next_tx_valid = 1'b0;
					next_tx_state = UFF_TX_IDLE;
				end
			end
			default:
			begin
				next_tx_valid = 1'b0;
				next_tx_state = UFF_TX_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			request_to_send_out_n <= RST_RTS_N;
			rts_en_q      <= 1'b0;
			cts_prev      <= 1'b1;
			tx_state      <= UFF_TX_IDLE;
			tx_char_valid <= 1'b0;
			tx_char_data  <= RST_REG;
		end
		else
		begin
			request_to_send_out_n <= next_rts_n;
			rts_en_q      <= next_rts_en;
			cts_prev      <= cts_sync;
			tx_state      <= next_tx_state;
			tx_char_valid <= next_tx_valid;
			tx_char_data  <= next_tx_data;
		end
	end

	// ****************************************
	// axi4-lite slave and register file
	// ****************************************
	always_comb
	begin
		next_aw_have = aw_have;
		next_aw_addr = aw_addr_q;
		next_w_have  = w_have;
		next_w_data  = w_data_q;
		next_w_strb  = w_strb_q;
		next_bvalid  = s_axi_bvalid;
		next_bresp   = s_axi_bresp;
		next_arready = s_axi_arready;
		next_rvalid  = s_axi_rvalid;
		next_rresp   = s_axi_rresp;
		next_rdata   = s_axi_rdata;
		next_fcr = fifo_control_reg;
		next_efr = enhanced_feature_reg;
		next_ier = interrupt_enable_reg;
		next_ttr = tx_trigger_level;
		next_rtr = rx_trigger_level;
		next_fut = flow_upper_threshold;
		next_flt = flow_lower_threshold;
		tx_push  = 3'h0;
		rx_want  = 3'h0;
		rd_val   = 32'h0;
		err_pend = 1'b0;
		wr_fire  = aw_have && w_have && !s_axi_bvalid;
		rd_fire  = s_axi_arvalid && s_axi_arready;
		strb_cnt = w_strb_q[3] ? 3'h4 : w_strb_q[1] ? 3'h2 : w_strb_q[0] ? 3'h1 : 3'h0;
		next_rts_irq = (rts_irq || (rts_rise && interrupt_enable_reg[IER_RTS_BIT]));
		next_cts_irq = (cts_irq || (cts_rise && interrupt_enable_reg[IER_CTS_BIT]));
		next_overrun = overrun;
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_aw_have = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_w_have = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready)
			next_bvalid = 1'b0;
		if (wr_fire)
		begin
			next_aw_have = 1'b0;
			next_w_have  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = RESP_OKAY;
			case (aw_addr_q)
				OFS_RX_BYTE:    tx_push = (CW'(strb_cnt) <= tx_space) ? strb_cnt : 3'h0;
				OFS_FIFO_CTRL:  if (w_strb_q[0]) next_fcr = w_data_q[7:0];
				OFS_ENH_FEAT:   if (w_strb_q[0]) next_efr = w_data_q[7:0];
				OFS_INT_EN:     if (w_strb_q[0]) next_ier = w_data_q[7:0];
				OFS_TX_TRIG:    if (w_strb_q[0]) next_ttr = w_data_q[7:0];
				OFS_RX_TRIG:    if (w_strb_q[0]) next_rtr = w_data_q[7:0];
				OFS_FLOW_UP:    if (w_strb_q[0]) next_fut = w_data_q[7:0];
				OFS_FLOW_LO:    if (w_strb_q[0]) next_flt = w_data_q[7:0];
				OFS_RX_HALF, OFS_RX_WORD, OFS_INT_STAT, OFS_MODEM_STAT, OFS_FLOW_STAT,
				OFS_TX_FREE, OFS_RX_FILL, OFS_LINE_STAT: next_bresp = RESP_OKAY;
				default:        next_bresp = RESP_SLVERR;
			endcase
		end
		next_awready = !next_aw_have && !next_bvalid;
		next_wready  = !next_w_have && !next_bvalid;
		for (int k = 0; k < UFF_LANES; k++)
		begin
			if (k < int'(rx_fill) && rx_head[16*k+8 +: 8] != 8'h00)
				err_pend = 1'b1;
		end
		case (s_axi_araddr)
			OFS_RX_BYTE:    rx_want = 3'h1;
			OFS_RX_HALF:    rx_want = 3'h2;
			OFS_RX_WORD:    rx_want = err_pend ? 3'h2 : 3'h4;
			OFS_FIFO_CTRL:  rd_val[7:0] = fifo_control_reg;
			OFS_ENH_FEAT:   rd_val[7:0] = enhanced_feature_reg;
			OFS_INT_EN:     rd_val[7:0] = interrupt_enable_reg;
			OFS_INT_STAT:   rd_val[7:0] = {CW'(tx_trigger_level) <= tx_space,
				CW'(rx_trigger_level) <= rx_fill, (rts_irq || cts_irq) ? ISR_FLOW : ISR_NONE};
			OFS_MODEM_STAT: rd_val[MSR_CTS_BIT] = !cts_sync;
			OFS_FLOW_STAT:
			begin
				rd_val[FSR_RTS_BIT] = enhanced_feature_reg[EFR_AUTO_RTS] && request_to_send_out_n;
				rd_val[FSR_CTS_BIT] = enhanced_feature_reg[EFR_AUTO_CTS] && cts_sync;
			end
			OFS_TX_TRIG:    rd_val[7:0] = tx_trigger_level;
			OFS_RX_TRIG:    rd_val[7:0] = rx_trigger_level;
			OFS_FLOW_UP:    rd_val[7:0] = flow_upper_threshold;
			OFS_FLOW_LO:    rd_val[7:0] = flow_lower_threshold;
			OFS_TX_FREE:    rd_val[CW-1:0] = tx_space;
			OFS_RX_FILL:    rd_val[CW-1:0] = rx_fill;
			OFS_LINE_STAT:  rd_val[LSR_OVR_BIT] = overrun;
			default:        rd_val = 32'h0;
		endcase
		rx_take = (rx_fill < CW'(rx_want)) ? rx_fill[2:0] : rx_want;
		for (int k = 0; k < UFF_LANES; k++)
		begin
			if (k < int'(rx_take))
			begin
				rd_val[8*k +: 8] = rx_head[16*k +: 8];
				if (rx_want != 3'h4)
					rd_val[16+8*k +: 8] = rx_head[16*k+8 +: 8];
			end
		end
		rx_pop = rd_fire ? rx_take : 3'h0;
		if (s_axi_rvalid && s_axi_rready)
		begin
			next_rvalid  = 1'b0;
			next_arready = 1'b1;
		end
		if (rd_fire)
		begin
			next_arready = 1'b0;
			next_rvalid  = 1'b1;
			next_rdata   = rd_val;
			next_rresp   = (s_axi_araddr[1:0] == 2'h0 && s_axi_araddr <= OFS_LINE_STAT)
				? RESP_OKAY : RESP_SLVERR;
			// status read clears, but an event in the same cycle still lands
			if (s_axi_araddr == OFS_MODEM_STAT)
			begin
				next_rts_irq = rts_rise && interrupt_enable_reg[IER_RTS_BIT];
				next_cts_irq = cts_rise && interrupt_enable_reg[IER_CTS_BIT];
			end
			if (s_axi_araddr == OFS_LINE_STAT)
				next_overrun = 1'b0;
		end
		if (rx_drop)
			next_overrun = 1'b1;
		next_irq = next_rts_irq || next_cts_irq;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have <= 1'b0;
			aw_addr_q <= RST_REG;
			w_have <= 1'b0;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= RESP_OKAY;
			s_axi_rdata <= 32'h0;
			fifo_control_reg <= RST_REG;
			enhanced_feature_reg <= RST_REG;
			interrupt_enable_reg <= RST_REG;
			tx_trigger_level <= RST_REG;
			rx_trigger_level <= RST_REG;
			flow_upper_threshold <= RST_REG;
			flow_lower_threshold <= RST_REG;
			rts_irq <= 1'b0;
			cts_irq <= 1'b0;
			overrun <= 1'b0;
			irq_out <= 1'b0;
		end
		else
		begin
			aw_have <= next_aw_have;
			aw_addr_q <= next_aw_addr;
			w_have <= next_w_have;
			w_data_q <= next_w_data;
			w_strb_q <= next_w_strb;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= next_arready || (!s_axi_arready && !s_axi_rvalid && !next_rvalid);
			s_axi_rvalid <= next_rvalid;
			s_axi_rresp <= next_rresp;
			s_axi_rdata <= next_rdata;
			fifo_control_reg <= next_fcr;
			enhanced_feature_reg <= next_efr;
			interrupt_enable_reg <= next_ier;
			tx_trigger_level <= next_ttr;
			rx_trigger_level <= next_rtr;
			flow_upper_threshold <= next_fut;
			flow_lower_threshold <= next_flt;
			rts_irq <= next_rts_irq;
			cts_irq <= next_cts_irq;
			overrun <= next_overrun;
			irq_out <= next_irq;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence rts_climb_s;
		enhanced_feature_reg[EFR_AUTO_RTS] && rts_en_q && !request_to_send_out_n
			&& rx_fill > upper;
	endsequence

	tx_discard_a: assert property (wr_fire && aw_addr_q == OFS_RX_BYTE
		&& CW'(strb_cnt) > tx_space |=> tx_fill <= $past(tx_fill))
		else $error("full transmit fifo accepted a write");
	rx_drop_a: assert property (rx_char_valid && rx_fill >= cap && rx_pop == 3'h0
		|=> overrun && rx_fill == $past(rx_fill))
		else $error("receive fifo grew past its capacity");
	rts_enable_a: assert property ($rose(enhanced_feature_reg[EFR_AUTO_RTS])
		|=> !request_to_send_out_n)
		else $error("request-to-send not low after enabling");
	rts_rise_a: assert property (rts_climb_s |=> request_to_send_out_n)
		else $error("request-to-send did not rise above upper level");
	rts_hold_a: assert property (enhanced_feature_reg[EFR_AUTO_RTS] && rts_en_q
		&& request_to_send_out_n && rx_fill > lower |=> request_to_send_out_n)
		else $error("request-to-send fell above lower level");
	flow_mirror_a: assert property (rd_fire && s_axi_araddr == OFS_FLOW_STAT
		&& enhanced_feature_reg[EFR_AUTO_RTS]
		|=> s_axi_rdata[FSR_RTS_BIT] == $past(request_to_send_out_n))
		else $error("flow status does not mirror request-to-send");
	rts_irq_a: assert property (rts_climb_s and interrupt_enable_reg[IER_RTS_BIT]
		|=> rts_irq && irq_out ##1 (rts_irq || $past(rd_fire)))
		else $error("rts rise did not raise interrupt");
	msr_clear_a: assert property (rd_fire && s_axi_araddr == OFS_MODEM_STAT && !rts_rise
		|=> !rts_irq)
		else $error("modem status read did not clear interrupt");
	cts_gate_a: assert property (cts_hold && !tx_char_valid |=> !tx_char_valid)
		else $error("transmit offered while clear-to-send holds it");
	rx_word_a: assert property (rd_fire && s_axi_araddr == OFS_RX_WORD && !err_pend
		&& rx_fill >= CW'(4) && !rx_char_valid
		|=> s_axi_rvalid && rx_fill == $past(rx_fill) - CW'(4))
		else $error("clean word read did not take four bytes");
endmodule // uff_flow_ctrl

// >>> logic/uff_pkg.sv
// constants shared by the flow-controlled uart fifo block
package uff_pkg;

	// ****************************************
	// fifo geometry
	// ****************************************
	localparam int UFF_DEPTH       = 256;
	localparam int UFF_DEPTH_SMALL = 64;
	localparam int UFF_LANES       = 4;

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] OFS_RX_BYTE    = 8'h00;	// read pops one, write pushes tx
	localparam logic [7:0] OFS_RX_HALF    = 8'h04;
	localparam logic [7:0] OFS_RX_WORD    = 8'h08;
	localparam logic [7:0] OFS_FIFO_CTRL  = 8'h0c;
	localparam logic [7:0] OFS_ENH_FEAT   = 8'h10;
	localparam logic [7:0] OFS_INT_EN     = 8'h14;
	localparam logic [7:0] OFS_INT_STAT   = 8'h18;
	localparam logic [7:0] OFS_MODEM_STAT = 8'h1c;
	localparam logic [7:0] OFS_FLOW_STAT  = 8'h20;
	localparam logic [7:0] OFS_TX_TRIG    = 8'h24;
	localparam logic [7:0] OFS_RX_TRIG    = 8'h28;
	localparam logic [7:0] OFS_FLOW_UP    = 8'h2c;
	localparam logic [7:0] OFS_FLOW_LO    = 8'h30;
	localparam logic [7:0] OFS_TX_FREE    = 8'h34;
	localparam logic [7:0] OFS_RX_FILL    = 8'h38;
	localparam logic [7:0] OFS_LINE_STAT  = 8'h3c;

	// ****************************************
	// field positions
	// ****************************************
	localparam int FCR_MODE256_BIT = 0;
	localparam int EFR_AUTO_CTS    = 7;
	localparam int EFR_AUTO_RTS    = 6;
	localparam int IER_CTS_BIT     = 7;
	localparam int IER_RTS_BIT     = 6;
	localparam int FSR_RTS_BIT     = 5;
	localparam int FSR_CTS_BIT     = 1;
	localparam int MSR_CTS_BIT     = 4;
	localparam int LSR_OVR_BIT     = 1;

	// ****************************************
	// reset values and codes
	// ****************************************
	localparam logic [7:0] RST_REG   = 8'h00;
	localparam logic       RST_RTS_N = 1'b1;
	localparam logic [5:0] ISR_NONE  = 6'h01;
	localparam logic [5:0] ISR_FLOW  = 6'h20;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// small-fifo thresholds, indexed by the two control bits
	localparam logic [7:0] UPPER_TAB [4] = '{8'h08, 8'h10, 8'h38, 8'h3c};
	localparam logic [7:0] LOWER_TAB [4] = '{8'h00, 8'h08, 8'h10, 8'h38};

	typedef enum logic [1:0] {
		UFF_TX_IDLE  = 2'h1,
		UFF_TX_OFFER = 2'h2
	} uff_tx_e;

endpackage

// >>> logic/uff_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module uff_sync
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic d,
	output logic      q
);
	logic meta;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta <= 1'b1;
			q    <= 1'b1;
		end
		else
		begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule // uff_sync
